// File: rtl/buf_ram.sv
`timescale 1ns/1ns
// byte-wide single-port data buffer with registered read data
module buf_ram #(
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // write or read on enable, read data registered
  always_ff @(posedge clk)
  begin
    if (en)
    begin
      if (we)
        mem[addr] <= wdata;
      rdata <= mem[addr];
    end
  end

endmodule

// File: rtl/cmd_pkg.sv
package cmd_pkg;

  // command codes
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h07;
  localparam logic [7:0] CMD_ENCRYPT = 8'h08;

  // argument byte positions
  localparam int ARG_PW_PAGE = 'h00;
  localparam int ARG_PW_COUNT = 'h01;
  localparam int ARG_PW_OFFSET = 'h02;
  localparam int ARG_EN_KEY = 'h00;
  localparam int ARG_EN_IV = 'h01;
  localparam int ARG_EN_OFFSET = 'h02;
  localparam int ARG_EN_COUNT = 'h03;

  // result codes
  localparam logic [7:0] RESULT_OK = 8'h00;
  localparam logic [7:0] RESULT_ERR = 8'h01;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // sizes and limits
  localparam int PAGE_BYTES = 4;
  localparam int BLOCK_BYTES = 16;
  localparam int MIN_BLOCKS = 1;
  localparam int MAX_BLOCKS = 8;
  localparam logic [7:0] SEL_MAX = 8'h01;
  localparam int BUF_BYTES_DEFAULT = 256;

  // command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PW_LOAD = 3'b001,
    ST_PW_WAIT = 3'b010,
    ST_EN_LOAD = 3'b011,
    ST_EN_AES = 3'b100,
    ST_EN_STORE = 3'b101
  } state_type;

  localparam state_type STATE_RESET = ST_IDLE;

endpackage

// File: rtl/page_write_and_cbc_encrypt_cmd.sv
`timescale 1ns/1ns
module page_write_and_cbc_encrypt_cmd #(
  parameter int BUF_BYTES = cmd_pkg::BUF_BYTES_DEFAULT,
  parameter int AW = $clog2(BUF_BYTES)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_arg0,
  input wire logic [7:0] cmd_arg1,
  input wire logic [7:0] cmd_arg2,
  input wire logic [7:0] cmd_arg3,
  output logic [7:0] result,
  output logic result_valid,
  output logic busy,
  input wire logic host_buf_en,
  input wire logic host_buf_we,
  input wire logic [AW-1:0] host_buf_addr,
  input wire logic [7:0] host_buf_wdata,
  output logic [7:0] host_buf_rdata,
  output logic tag_req,
  output logic [7:0] tag_page,
  output logic [31:0] tag_data,
  input wire logic tag_ack,
  input wire logic tag_ok,
  input wire logic [127:0] key0,
  input wire logic [127:0] key1,
  input wire logic [127:0] iv0,
  input wire logic [127:0] iv1,
  output logic aes_start,
  output logic [127:0] aes_key,
  output logic [127:0] aes_din,
  input wire logic aes_done,
  input wire logic [127:0] aes_dout
);

  typedef struct packed {
    cmd_pkg::state_type st;
    logic [AW-1:0] ptr;
    logic [3:0] idx;
    logic got;
    logic [7:0] cnt;
    logic [7:0] page;
    logic [127:0] data;
    logic [127:0] chain;
    logic [127:0] key;
    logic req;
    logic start;
    logic [7:0] result;
    logic rvalid;
  } regs_type;

  regs_type s;
  regs_type next_s;
  logic ram_en;
  logic ram_we;
  logic [AW-1:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [15:0] pw_end;
  logic [15:0] en_end;
  logic pw_bad;
  logic en_bad;
  logic [127:0] loaded;
  localparam logic [3:0] PAGE_LAST = 4'(cmd_pkg::PAGE_BYTES - 1);
  localparam logic [3:0] BLOCK_LAST = 4'(cmd_pkg::BLOCK_BYTES - 1);
  localparam logic [AW-1:0] BLOCK_STEP = AW'(cmd_pkg::BLOCK_BYTES);
  // shift one buffer byte into the low end of the staging word
  function automatic logic [127:0] shift_in(input logic [127:0] w, input logic [7:0] b);
    shift_in = {w[119:0], b};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // data buffer
  buf_ram #(
    .DEPTH(BUF_BYTES),
    .AW(AW)
  ) u_buf (
    .clk(clk),
    .en(ram_en),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );
  ////////////////////////////////////////////////////////////////////////////
  // argument range checks
  always_comb
  begin
    pw_end = 16'(cmd_arg2) + 16'(cmd_arg1) * 16'(cmd_pkg::PAGE_BYTES);
    en_end = (16'(cmd_arg2) + 16'(cmd_arg3)) * 16'(cmd_pkg::BLOCK_BYTES);
    pw_bad = (cmd_arg1 == 8'h00) || (pw_end > 16'(BUF_BYTES));
    en_bad = (cmd_arg0 > cmd_pkg::SEL_MAX) || (cmd_arg1 > cmd_pkg::SEL_MAX)
      || (cmd_arg3 < 8'(cmd_pkg::MIN_BLOCKS)) || (cmd_arg3 > 8'(cmd_pkg::MAX_BLOCKS))
      || (en_end > 16'(BUF_BYTES));
    loaded = shift_in(s.data, ram_rdata);
  end
  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb
  begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.start = 1'b0;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = s.ptr;
    ram_wdata = s.data[127:120];
    case (s.st)
      cmd_pkg::ST_IDLE:
      begin
        // host owns the buffer while idle
        ram_en = host_buf_en;
        ram_we = host_buf_we;
        ram_addr = host_buf_addr;
        ram_wdata = host_buf_wdata;
        if (cmd_valid)
        begin
          next_s.idx = 4'h0;
          next_s.got = 1'b0;
          next_s.rvalid = 1'b1;
          next_s.result = cmd_pkg::RESULT_ERR;
          if (cmd_code == cmd_pkg::CMD_PAGE_WRITE)
          begin
            if (!pw_bad)
            begin
              next_s.rvalid = 1'b0;
              next_s.page = cmd_arg0;
              next_s.cnt = cmd_arg1;
              next_s.ptr = AW'(cmd_arg2);
              next_s.st = cmd_pkg::ST_PW_LOAD;
            end
          end
          else if (cmd_code == cmd_pkg::CMD_ENCRYPT)
          begin
            if (!en_bad)
            begin
              next_s.rvalid = 1'b0;
              next_s.key = cmd_arg0[0] ? key1 : key0;
              next_s.chain = cmd_arg1[0] ? iv1 : iv0;
              next_s.ptr = AW'(16'(cmd_arg2) * 16'(cmd_pkg::BLOCK_BYTES));
              next_s.cnt = cmd_arg3;
              next_s.st = cmd_pkg::ST_EN_LOAD;
            end
          end
        end
      end
      cmd_pkg::ST_PW_LOAD:
      begin
        // two cycles per byte: issue read, then take registered data
        ram_en = !s.got;
        next_s.got = !s.got;
        if (s.got)
        begin
          next_s.data = loaded;
          next_s.ptr = s.ptr + 1'b1;
          next_s.idx = s.idx + 1'b1;
          if (s.idx == PAGE_LAST)
          begin
            next_s.idx = 4'h0;
            next_s.req = 1'b1;
            next_s.st = cmd_pkg::ST_PW_WAIT;
          end
        end
      end
      cmd_pkg::ST_PW_WAIT:
      begin
        if (tag_ack)
        begin
          next_s.req = 1'b0;
          if (!tag_ok)
          begin
            next_s.result = cmd_pkg::RESULT_ERR;
            next_s.rvalid = 1'b1;
            next_s.st = cmd_pkg::ST_IDLE;
          end
          else if (s.cnt > 8'h01)
          begin
            next_s.cnt = s.cnt - 1'b1;
            next_s.page = s.page + 1'b1;
            next_s.st = cmd_pkg::ST_PW_LOAD;
          end
          else
          begin
            next_s.result = cmd_pkg::RESULT_OK;
            next_s.rvalid = 1'b1;
            next_s.st = cmd_pkg::ST_IDLE;
          end
        end
      end
      cmd_pkg::ST_EN_LOAD:
      begin
        ram_en = !s.got;
        next_s.got = !s.got;
        if (s.got)
        begin
          next_s.data = loaded;
          next_s.ptr = s.ptr + 1'b1;
          next_s.idx = s.idx + 1'b1;
          if (s.idx == BLOCK_LAST)
          begin
            next_s.idx = 4'h0;
            next_s.data = loaded ^ s.chain;
            next_s.start = 1'b1;
            next_s.st = cmd_pkg::ST_EN_AES;
          end
        end
      end
      cmd_pkg::ST_EN_AES:
      begin
        if (aes_done)
        begin
          next_s.data = aes_dout;
          next_s.chain = aes_dout;
          next_s.ptr = s.ptr - BLOCK_STEP;
          next_s.st = cmd_pkg::ST_EN_STORE;
        end
      end
      cmd_pkg::ST_EN_STORE:
      begin
        // write ciphertext back over the block just read
        ram_en = 1'b1;
        ram_we = 1'b1;
        next_s.data = {s.data[119:0], 8'h00};
        next_s.ptr = s.ptr + 1'b1;
        next_s.idx = s.idx + 1'b1;
        if (s.idx == BLOCK_LAST)
        begin
          next_s.idx = 4'h0;
          if (s.cnt > 8'h01)
          begin
            next_s.cnt = s.cnt - 1'b1;
            next_s.st = cmd_pkg::ST_EN_LOAD;
          end
          else
          begin
            next_s.result = cmd_pkg::RESULT_OK;
            next_s.rvalid = 1'b1;
            next_s.st = cmd_pkg::ST_IDLE;
          end
        end
      end
      default: next_s.st = cmd_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= cmd_pkg::STATE_RESET;
      s.result <= cmd_pkg::RESULT_RESET;
    end
    else
      s <= next_s;
  end

  // outputs
  assign cmd_ready = (s.st == cmd_pkg::ST_IDLE);
  assign busy = (s.st != cmd_pkg::ST_IDLE);
  assign result = s.result;
  assign result_valid = s.rvalid;
  assign host_buf_rdata = ram_rdata;
  assign tag_req = s.req;
  assign tag_page = s.page;
  assign tag_data = s.data[31:0];
  assign aes_start = s.start;
  assign aes_key = s.key;
  assign aes_din = s.data;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_pw_decode: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_ready && cmd_valid && cmd_code == cmd_pkg::CMD_PAGE_WRITE && !pw_bad
    |=> s.st == cmd_pkg::ST_PW_LOAD && tag_page == $past(cmd_arg0) ##[7:8] tag_req)
    else $error("page write not started");
  a_en_decode: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_ready && cmd_valid && cmd_code == cmd_pkg::CMD_ENCRYPT && !en_bad
    |=> s.st == cmd_pkg::ST_EN_LOAD ##[32:33] aes_start)
    else $error("encryption not started");
  a_pw_next_page: assert property (@(posedge clk) disable iff (!rst_n)
    s.st == cmd_pkg::ST_PW_WAIT && tag_ack && tag_ok && s.cnt > 8'h01
    |=> tag_page == $past(tag_page) + 8'h01 && !tag_req ##8 tag_req)
    else $error("next page not written");
  a_pw_fail_stop: assert property (@(posedge clk) disable iff (!rst_n)
    s.st == cmd_pkg::ST_PW_WAIT && tag_ack && !tag_ok
    |=> result_valid && result == cmd_pkg::RESULT_ERR && !tag_req && !busy ##1 !tag_req)
    else $error("failed write not reported");
  a_pw_ok_last: assert property (@(posedge clk) disable iff (!rst_n)
    s.st == cmd_pkg::ST_PW_WAIT && tag_ack && tag_ok && s.cnt == 8'h01
    |=> result_valid && result == cmd_pkg::RESULT_OK)
    else $error("no-error result missing");
  a_bad_args: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_ready && cmd_valid && ((cmd_code == cmd_pkg::CMD_ENCRYPT && en_bad)
    || (cmd_code == cmd_pkg::CMD_PAGE_WRITE && pw_bad))
    |=> result_valid && result == cmd_pkg::RESULT_ERR && !busy && !tag_req && !aes_start)
    else $error("bad arguments not refused");
  a_key_stable: assert property (@(posedge clk) disable iff (!rst_n)
    s.st != cmd_pkg::ST_IDLE && $past(s.st) != cmd_pkg::ST_IDLE
    && s.st >= cmd_pkg::ST_EN_LOAD |-> $stable(aes_key))
    else $error("key changed inside command");
  a_chain_load: assert property (@(posedge clk) disable iff (!rst_n)
    s.st == cmd_pkg::ST_EN_AES && aes_done
    |=> s.chain == $past(aes_dout) && ram_we && ram_wdata == $past(aes_dout[127:120]))
    else $error("ciphertext not chained");
  a_store_place: assert property (@(posedge clk) disable iff (!rst_n)
    s.st == cmd_pkg::ST_EN_AES && aes_done
    |=> ram_addr == $past(s.ptr) - BLOCK_STEP [*1] ##15 s.st == cmd_pkg::ST_EN_STORE)
    else $error("ciphertext stored out of place");
  a_start_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    aes_start |=> !aes_start && s.st == cmd_pkg::ST_EN_AES)
    else $error("cipher start not a single pulse");
endmodule

// File: tb/far_side_model.sv
`timescale 1ns/1ns
// tag front end and aes core stand-ins, prompt or slow
module far_side_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] fail_page,
  input wire logic tag_req,
  input wire logic [7:0] tag_page,
  input wire logic [31:0] tag_data,
  output logic tag_ack,
  output logic tag_ok,
  input wire logic aes_start,
  input wire logic [127:0] aes_key,
  input wire logic [127:0] aes_din,
  output logic aes_done,
  output logic [127:0] aes_dout
);
  logic [31:0] pages [0:255];
  logic [3:0] tag_cnt;
  logic [3:0] aes_cnt;
  logic aes_busy;
  logic [127:0] hold;

  initial
  begin
    for (int i = 0; i < 256; i++) pages[i] = 32'h0;
    {tag_ack, tag_ok, aes_done, aes_busy} = 4'h0;
    tag_cnt = 4'h0;
    aes_cnt = 4'h0;
    aes_dout = 128'h0;
  end

  ////////////////////////////////////////////////////////////////
  // one page write at a time; a page without authentication refuses
  always @(posedge clk)
  begin
    tag_ack <= 1'b0;
    tag_ok <= ~tag_ok;
    if (tag_req && !tag_ack)
    begin
      if (tag_cnt == (slow ? 4'h9 : 4'h1))
      begin
        tag_ack <= 1'b1;
        tag_ok <= (tag_page != fail_page);
        if (tag_page != fail_page) pages[tag_page] <= tag_data;
        tag_cnt <= 4'h0;
      end
      else tag_cnt <= tag_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // toy cipher: halves swapped, then key mixed in; stale output scrambled
  always @(posedge clk)
  begin
    aes_done <= 1'b0;
    aes_dout <= ~aes_dout;
    if (aes_start)
    begin
      aes_busy <= 1'b1;
      aes_cnt <= 4'h0;
      hold <= {aes_din[63:0], aes_din[127:64]} ^ aes_key;
    end
    else if (aes_busy)
    begin
      if (aes_cnt == (slow ? 4'hc : 4'h0))
      begin
        aes_done <= 1'b1;
        aes_dout <= hold;
        aes_busy <= 1'b0;
      end
      else aes_cnt <= aes_cnt + 4'h1;
    end
  end
endmodule

// File: tb/page_write_and_cbc_encrypt_cmd_tb_top.sv
`timescale 1ns/1ns
module page_write_and_cbc_encrypt_cmd_tb_top;
  typedef struct packed {logic [7:0] code, a0, a1, a2, a3, res;} row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h0, a0 = 8'h0, a1 = 8'h0, a2 = 8'h0, a3 = 8'h0;
  logic en = 1'b0, we = 1'b0, slow = 1'b0;
  logic [7:0] addr = 8'h0, wdata = 8'h0, fail_page = 8'hff;
  logic [127:0] key0 = 128'h0123456789abcdef0f1e2d3c4b5a6978;
  logic [127:0] key1 = 128'hfedcba98765432100011223344556677;
  logic [127:0] iv0 = 128'h55aa55aa11223344deadbeef01020304;
  logic [127:0] iv1 = 128'h1357913579bdf02468ace02468ace0ff;
  logic cmd_ready, result_valid, busy, tag_req, tag_ack, tag_ok, aes_start, aes_done;
  logic [7:0] result, rdata, tag_page;
  logic [31:0] tag_data;
  logic [127:0] aes_key, aes_din, aes_dout, c, got;
  int n_fail = 0, compares = 0;
  row_type rows [12];

  always #5 clk = ~clk;

  page_write_and_cbc_encrypt_cmd dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_arg0(a0), .cmd_arg1(a1),
    .cmd_arg2(a2), .cmd_arg3(a3), .result(result), .result_valid(result_valid),
    .busy(busy), .host_buf_en(en), .host_buf_we(we), .host_buf_addr(addr),
    .host_buf_wdata(wdata), .host_buf_rdata(rdata), .tag_req(tag_req),
    .tag_page(tag_page), .tag_data(tag_data), .tag_ack(tag_ack), .tag_ok(tag_ok),
    .key0(key0), .key1(key1), .iv0(iv0), .iv1(iv1), .aes_start(aes_start),
    .aes_key(aes_key), .aes_din(aes_din), .aes_done(aes_done), .aes_dout(aes_dout));

  far_side_model far (.clk(clk), .slow(slow), .fail_page(fail_page), .tag_req(tag_req),
    .tag_page(tag_page), .tag_data(tag_data), .tag_ack(tag_ack), .tag_ok(tag_ok),
    .aes_start(aes_start), .aes_key(aes_key), .aes_din(aes_din), .aes_done(aes_done),
    .aes_dout(aes_dout));

  ////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic run_cmd(input row_type r);
    @(negedge clk);
    {cmd_code, a0, a1, a2, a3} = {r.code, r.a0, r.a1, r.a2, r.a3};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int k = 0; k < 3000 && result_valid !== 1'b1; k++) @(negedge clk);
    chk(result_valid, 1'b1);
    chk(result, r.res);
  endtask

  task automatic rdblk(input int b, output logic [127:0] v);
    for (int j = 0; j <= 16; j++)
    begin
      @(negedge clk);
      if (j > 0) v = {v[119:0], rdata};
      en = (j < 16);
      addr = 8'(16 * b + j);
    end
  endtask

  function automatic logic [127:0] plain(input int b);
    logic [127:0] r;
    for (int j = 0; j < 16; j++) r = {r[119:0], 8'(16 * b + j)};
    return r;
  endfunction

  function automatic logic [127:0] toy(input logic [127:0] k, input logic [127:0] d);
    return {d[63:0], d[127:64]} ^ k;
  endfunction

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rows = '{
      '{8'h07, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00},
      '{8'h07, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
      '{8'h07, 8'h04, 8'h02, 8'hfc, 8'h00, 8'h01},
      '{8'h07, 8'h09, 8'h01, 8'hfc, 8'h00, 8'h00},
      '{8'h08, 8'h00, 8'h01, 8'h01, 8'h02, 8'h00},
      '{8'h08, 8'h01, 8'h00, 8'h0f, 8'h01, 8'h00},
      '{8'h08, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01},
      '{8'h08, 8'h00, 8'h02, 8'h00, 8'h01, 8'h01},
      '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01},
      '{8'h08, 8'h00, 8'h00, 8'h00, 8'h09, 8'h01},
      '{8'h08, 8'h00, 8'h00, 8'h0f, 8'h02, 8'h01},
      '{8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01}};
    repeat (7) @(negedge clk);
    rst_n = 1'b1;
    chk({result, cmd_ready, busy}, {8'h00, 2'b10});
    // buffer byte i holds i
    for (int i = 0; i < 256; i++)
    begin
      @(negedge clk);
      {en, we, addr, wdata} = {2'b11, 8'(i), 8'(i)};
    end
    @(negedge clk);
    {en, we} = 2'b00;
    foreach (rows[i]) run_cmd(rows[i]);
    chk(far.pages[4], 32'h00010203);
    chk(far.pages[5], 32'h04050607);
    chk(far.pages[9], 32'hfcfdfeff);
    c = iv1;
    for (int b = 1; b < 3; b++)
    begin
      c = toy(key0, plain(b) ^ c);
      rdblk(b, got);
      chk(got, c);
    end
    rdblk(0, got);
    chk(got, plain(0));
    rdblk(3, got);
    chk(got, plain(3));
    rdblk(15, got);
    chk(got, toy(key1, plain(15) ^ iv0));
    // slow far side, refused second page stops the command
    slow = 1'b1;
    fail_page = 8'h22;
    run_cmd('{8'h07, 8'h21, 8'h03, 8'h00, 8'h00, 8'h01});
    chk({far.pages[8'h21], far.pages[8'h22], far.pages[8'h23]}, {32'h00010203, 64'h0});
    run_cmd('{8'h08, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00});
    rdblk(0, got);
    chk(got, toy(key1, plain(0) ^ iv0));
    // reset in mid-encryption: back to idle, reset result, chain restarts
    run_cmd('{8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01});
    @(negedge clk);
    {cmd_code, a0, a1, a2, a3} = {8'h08, 8'h00, 8'h00, 8'h04, 8'h01};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk({busy, cmd_ready}, 2'b10);
    repeat (10) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk({result, result_valid, cmd_ready, busy}, {8'h00, 3'b010});
    run_cmd('{8'h08, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00});
    rdblk(4, got);
    chk(got, toy(key0, plain(4) ^ iv0));
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected run of under a thousand cycles
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
